// >>> hw/ebc_defines.vh
// Register map, field positions and reset values of the bus configuration.
`ifndef EBC_DEFINES_VH
`define EBC_DEFINES_VH
`define EBC_AW          8
`define EBC_IDX_BCC     1
`define EBC_ADDR_BCC    8'h04
`define EBC_ADDR_CFG2   8'h08
`define EBC_ADDR_CTRL   8'h0C
`define EBC_ADDR_STAT   8'h10
`define EBC_BIT_EXTENDED_BUS_ENABLE   15
`define EBC_BIT_RSVD    14
`define EBC_BIT_LATCH   13
`define EBC_BIT_PO_HI   12
`define EBC_BIT_PO_LO   11
`define EBC_BIT_SYNC_BUS_SELECT    10
`define EBC_EXU_HI      15
`define EBC_EXU_LO      12
`define EBC_CTRL_RSTM   0
`define EBC_CTRL_STYLE  1
`define EBC_CTRL_SWRST  2
`define EBC_STAT_FLAG   0
`define EBC_STAT_MASTER 1
`define EBC_STAT_STOP   2
`define EBC_STAT_RETRY  3
`define EBC_CTRL_RST    2'h1
`define EBC_CFG2_RST    16'h0000
`define EBC_RESP_OKAY   2'h0
`define EBC_RESP_SLVERR 2'h2
`define EBC_ST_RUN      2'h0
`define EBC_ST_DRAIN    2'h1
`define EBC_ST_WAIT     2'h2
`endif

// >>> hw/ebc_top.v
// Bus cycle configuration register bank with pin muxing and retry control.
//
// Overview of operation
// RL1: 16-bit config register at index 1.
// RL2: Hardware reset clears bits 15, 13 only.
// RL3: Software reset keeps config register intact.
// RL4: Host accesses register only in reset mode; the code accepts accesses whatever reset_mode is.
// RL5: Host programs register first after reset.
// RL6: Extended mode: four pins become user outputs.
// RL7: Extra outputs float until register rewritten.
// RL8: Extra outputs driven only while bus master.
// RL9: Normal mode: pins are encoder interface.
// RL10: Extended mode: tx clock pin becomes termination.
// RL11: Termination honoured only async, 68k-style bus.
// RL12: Termination pin floats until master, then input.
// RL13: Normal mode: termination pin is tx clock.
// RL14: Extended async: retry sampled on falling edge.
// RL15: Otherwise retry sampled on rising edge.
// RL16: Unlatched retry: finish, release, resume on deassert.
// RL17: Latched retry: resume after flag cleared too.
// RL18: Output bits 12, 11 drive user pins.
// RL19: Host writes zero to reserved bit 14.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "ebc_defines.vh"

module ebc_top (
  input  wire                 aclk,
  input  wire                 aresetn,
  input  wire [`EBC_AW-1:0]   s_axi_awaddr,
  input  wire                 s_axi_awvalid,
  output wire                 s_axi_awready,
  input  wire [31:0]          s_axi_wdata,
  input  wire [3:0]           s_axi_wstrb,
  input  wire                 s_axi_wvalid,
  output wire                 s_axi_wready,
  output wire [1:0]           s_axi_bresp,
  output wire                 s_axi_bvalid,
  input  wire                 s_axi_bready,
  input  wire [`EBC_AW-1:0]   s_axi_araddr,
  input  wire                 s_axi_arvalid,
  output wire                 s_axi_arready,
  output wire [31:0]          s_axi_rdata,
  output wire [1:0]           s_axi_rresp,
  output wire                 s_axi_rvalid,
  input  wire                 s_axi_rready,
  input  wire                 bus_grant,
  input  wire                 dma_active,
  output wire                 dma_stop,
  input  wire                 bus_retry_in,
  input  wire                 mac_txd,
  input  wire                 mac_loopback,
  output wire                 mac_rx_clock,
  output wire                 mac_rxd,
  output wire                 mac_tx_clock,
  output wire                 sync_term_valid,
  output wire                 sync_termination_in,
  input  wire                 txd_pin_i,
  output wire                 txd_pin_o,
  output wire                 txd_pin_oe,
  input  wire                 lbk_pin_i,
  output wire                 lbk_pin_o,
  output wire                 lbk_pin_oe,
  input  wire                 rxc_pin_i,
  output wire                 rxc_pin_o,
  output wire                 rxc_pin_oe,
  input  wire                 rxd_pin_i,
  output wire                 rxd_pin_o,
  output wire                 rxd_pin_oe,
  input  wire                 txc_pin_i,
  output wire                 user_pin_hi_o,
  output wire                 user_pin_hi_oe,
  output wire                 user_pin_lo_o,
  output wire                 user_pin_lo_oe,
  output wire [15:0]          bus_cycle_config,
  output wire                 reset_mode
);

  reg  [15:0]        bcc_ff;
  reg  [15:0]        cfg2_ff;
  reg  [1:0]         ctrl_ff;
  reg                cfg_written_ff;
  reg  [`EBC_AW-1:0] aw_addr_ff;
  reg                aw_full_ff;
  reg  [31:0]        w_data_ff;
  reg  [3:0]         w_strb_ff;
  reg                w_full_ff;
  reg                bvalid_ff;
  reg  [1:0]         bresp_ff;
  reg                rvalid_ff;
  reg  [31:0]        rdata_ff;
  reg  [1:0]         rresp_ff;
  reg                retry_pos_ff;
  reg                retry_neg_ff;
  reg                retry_prev_ff;
  reg                flag_ff;
  reg  [1:0]         state_ff;
  reg  [1:0]         nxt_state;
  reg  [15:0]        nxt_bcc;
  reg  [15:0]        nxt_cfg2;
  reg  [31:0]        nxt_rdata;
  reg  [1:0]         nxt_rresp;
  reg                wr_ok;

  wire do_write = aw_full_ff & w_full_ff & ~bvalid_ff;
  wire do_read  = s_axi_arvalid & ~rvalid_ff;
  wire wr_bcc   = do_write & (aw_addr_ff == `EBC_ADDR_BCC);
  wire wr_cfg2  = do_write & (aw_addr_ff == `EBC_ADDR_CFG2);
  wire wr_ctrl  = do_write & (aw_addr_ff == `EBC_ADDR_CTRL);
  wire wr_stat  = do_write & (aw_addr_ff == `EBC_ADDR_STAT);
  wire soft_rst = wr_ctrl & w_strb_ff[0] & w_data_ff[`EBC_CTRL_SWRST];

  wire ext_mode  = bcc_ff[`EBC_BIT_EXTENDED_BUS_ENABLE];
  wire sync_bus  = bcc_ff[`EBC_BIT_SYNC_BUS_SELECT];
  wire latched   = bcc_ff[`EBC_BIT_LATCH];
  wire style_68k = ctrl_ff[`EBC_CTRL_STYLE];
  wire drive_ext = cfg_written_ff & ext_mode & bus_grant;
  wire retry_lvl = (ext_mode & ~sync_bus) ? retry_neg_ff : retry_pos_ff;
  wire retry_new = retry_lvl & ~retry_prev_ff;

  assign s_axi_awready = ~aw_full_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_full_ff & ~bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // Write channel capture; address and data may arrive in either order.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_ff <= 1'b0;
      w_full_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `EBC_RESP_OKAY;
      aw_addr_ff <= {`EBC_AW{1'b0}};
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_addr_ff <= s_axi_awaddr;
        aw_full_ff <= 1'b1;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
        w_full_ff <= 1'b1;
      end
      if (do_write) begin
        aw_full_ff <= 1'b0;
        w_full_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wr_ok ? `EBC_RESP_OKAY : `EBC_RESP_SLVERR;
      end else if (bvalid_ff & s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always @* begin
    wr_ok = wr_bcc | wr_cfg2 | wr_ctrl | wr_stat;
    nxt_bcc[15:8] = w_strb_ff[1] ? w_data_ff[15:8] : bcc_ff[15:8];
    nxt_bcc[7:0]  = w_strb_ff[0] ? w_data_ff[7:0] : bcc_ff[7:0];
    // RL19 Reserved bit zero.
    nxt_bcc[`EBC_BIT_RSVD] = 1'b0;
    nxt_cfg2[15:8] = w_strb_ff[1] ? w_data_ff[15:8] : cfg2_ff[15:8];
    nxt_cfg2[7:0]  = w_strb_ff[0] ? w_data_ff[7:0] : cfg2_ff[7:0];
  end

  // RL1 Configuration register storage.
  // RL2 Partial hardware reset.
  // RL3 No software reset term.
  // Bits other than 15 and 13 hold whatever they held before the reset.
  always @(posedge aclk) begin
    if (!aresetn) begin
      bcc_ff[`EBC_BIT_EXTENDED_BUS_ENABLE] <= 1'b0;
      bcc_ff[`EBC_BIT_LATCH] <= 1'b0;
    end else if (wr_bcc) begin
      bcc_ff <= nxt_bcc;
    end
  end

  // RL7 Pins float until rewritten.
  always @(posedge aclk) begin
    if (!aresetn) begin
      cfg_written_ff <= 1'b0;
      cfg2_ff        <= `EBC_CFG2_RST;
      ctrl_ff        <= `EBC_CTRL_RST;
    end else begin
      if (wr_bcc) begin
        cfg_written_ff <= 1'b1;
      end
      if (wr_cfg2) begin
        cfg2_ff <= nxt_cfg2;
      end
      if (wr_ctrl & w_strb_ff[0]) begin
        ctrl_ff <= w_data_ff[1:0];
      end
    end
  end

  // Register read decode.
  always @* begin
    nxt_rdata = 32'h0000_0000;
    nxt_rresp = `EBC_RESP_OKAY;
    if (s_axi_araddr == `EBC_ADDR_BCC) begin
      nxt_rdata[15:0] = bcc_ff;
    end else if (s_axi_araddr == `EBC_ADDR_CFG2) begin
      nxt_rdata[15:0] = cfg2_ff;
    end else if (s_axi_araddr == `EBC_ADDR_CTRL) begin
      nxt_rdata[1:0] = ctrl_ff;
    end else if (s_axi_araddr == `EBC_ADDR_STAT) begin
      nxt_rdata[`EBC_STAT_FLAG]   = flag_ff;
      nxt_rdata[`EBC_STAT_MASTER] = bus_grant;
      nxt_rdata[`EBC_STAT_STOP]   = dma_stop;
      nxt_rdata[`EBC_STAT_RETRY]  = retry_lvl;
    end else begin
      nxt_rresp = `EBC_RESP_SLVERR;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= `EBC_RESP_OKAY;
    end else if (do_read) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
    end else if (rvalid_ff & s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // RL15 Rising edge sample.
  always @(posedge aclk) begin
    if (!aresetn) begin
      retry_pos_ff <= 1'b0;
    end else begin
      retry_pos_ff <= bus_retry_in;
    end
  end

  // RL14 Falling edge sample.
  // Half a cycle earlier than the rising sample, traded for tighter timing.
  always @(negedge aclk) begin
    if (!aresetn) begin
      retry_neg_ff <= 1'b0;
    end else begin
      retry_neg_ff <= bus_retry_in;
    end
  end

  // RL17 Retry flag, set wins.
  always @(posedge aclk) begin
    if (!aresetn | soft_rst) begin
      retry_prev_ff <= 1'b0;
      flag_ff       <= 1'b0;
    end else begin
      retry_prev_ff <= retry_lvl;
      if (retry_new) begin
        flag_ff <= 1'b1;
      end else if (wr_stat & w_strb_ff[0] & w_data_ff[`EBC_STAT_FLAG]) begin
        flag_ff <= 1'b0;
      end
    end
  end

  // RL16 Drain, release, resume.
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      `EBC_ST_RUN: begin
        if (retry_lvl) begin
          nxt_state = `EBC_ST_DRAIN;
        end
      end
      `EBC_ST_DRAIN: begin
        if (!dma_active) begin
          nxt_state = `EBC_ST_WAIT;
        end
      end
      `EBC_ST_WAIT: begin
        // RL17 Latched resume gate.
        if (!retry_lvl && !(latched && flag_ff)) begin
          nxt_state = `EBC_ST_RUN;
        end
      end
      default: begin
        nxt_state = `EBC_ST_RUN;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn | soft_rst) begin
      state_ff <= `EBC_ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign dma_stop = (state_ff != `EBC_ST_RUN);

  // RL6 Extra user outputs.
  // RL8 Driven while master.
  // RL9 Normal encoder pins.
  assign txd_pin_o  = ext_mode ? cfg2_ff[`EBC_EXU_HI - 3] : mac_txd;
  assign lbk_pin_o  = ext_mode ? cfg2_ff[`EBC_EXU_HI - 2] : mac_loopback;
  assign rxc_pin_o  = cfg2_ff[`EBC_EXU_HI - 1];
  assign rxd_pin_o  = cfg2_ff[`EBC_EXU_HI];
  assign txd_pin_oe = ext_mode ? drive_ext : cfg_written_ff;
  assign lbk_pin_oe = ext_mode ? drive_ext : cfg_written_ff;
  assign rxc_pin_oe = drive_ext;
  assign rxd_pin_oe = drive_ext;
  assign mac_rx_clock = ext_mode ? 1'b0 : rxc_pin_i;
  assign mac_rxd      = ext_mode ? 1'b0 : rxd_pin_i;

  // RL13 Normal tx clock.
  assign mac_tx_clock = ext_mode ? 1'b0 : txc_pin_i;

  // RL10 Termination input.
  // RL11 Qualified termination.
  // RL12 Only once master.
  assign sync_term_valid = drive_ext & ~sync_bus & style_68k;
  assign sync_termination_in = sync_term_valid & ~txc_pin_i;

  // RL18 User pin levels.
  assign user_pin_hi_o  = bcc_ff[`EBC_BIT_PO_HI];
  assign user_pin_lo_o  = bcc_ff[`EBC_BIT_PO_LO];
  assign user_pin_hi_oe = bus_grant;
  assign user_pin_lo_oe = bus_grant;

  assign bus_cycle_config = bcc_ff;
  assign reset_mode       = ctrl_ff[`EBC_CTRL_RSTM];

endmodule // ebc_top

// >>> tb/ebc_top_asserts.sv
// Concurrent checks on the pin muxing and retry behaviour of ebc_top.
`timescale 1ns/1ps
module ebc_top_asserts (
  input wire        aclk,
  input wire        aresetn,
  input wire [15:0] bus_cycle_config,
  input wire        bus_grant,
  input wire        dma_active,
  input wire        dma_stop,
  input wire        bus_retry_in,
  input wire        txc_pin_i,
  input wire        mac_tx_clock,
  input wire        sync_term_valid,
  input wire        sync_termination_in,
  input wire        txd_pin_oe,
  input wire        lbk_pin_oe,
  input wire        rxc_pin_oe,
  input wire        rxd_pin_oe,
  input wire        user_pin_hi_o,
  input wire        user_pin_hi_oe,
  input wire        user_pin_lo_o,
  input wire        user_pin_lo_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire ext = bus_cycle_config[15];
  sequence retry_s;
    $rose(bus_retry_in) && !dma_stop;
  endsequence
  // Unlatched mode only; latched resume also waits for software.
  sequence quiet_s;
    !bus_retry_in && !dma_active && !bus_cycle_config[13];
  endsequence
  reset_clear_a: assert property (disable iff (1'b0)
    !aresetn |=> !bus_cycle_config[15] && !bus_cycle_config[13])
    else $error("config bits kept through reset");
  user_enable_a: assert property (
    user_pin_hi_oe == bus_grant && user_pin_lo_oe == bus_grant)
    else $error("user pin enable wrong");
  user_level_a: assert property (bus_grant |->
    user_pin_hi_o == bus_cycle_config[12] &&
    user_pin_lo_o == bus_cycle_config[11])
    else $error("user pin level wrong");
  ext_float_a: assert property (ext && !bus_grant |->
    !(txd_pin_oe || lbk_pin_oe || rxc_pin_oe || rxd_pin_oe))
    else $error("extra output driven without mastership");
  normal_pins_a: assert property (!ext |->
    mac_tx_clock == txc_pin_i && !rxc_pin_oe && !rxd_pin_oe)
    else $error("encoder pins wrong in normal mode");
  ext_txclk_a: assert property (ext |-> !mac_tx_clock)
    else $error("tx clock passed in extended mode");
  term_gate_a: assert property (sync_term_valid |->
    ext && !bus_cycle_config[10] && bus_grant)
    else $error("termination honoured outside its mode");
  term_level_a: assert property (
    sync_termination_in == (sync_term_valid && !txc_pin_i))
    else $error("termination level wrong");
  retry_stop_a: assert property (retry_s |-> ##[1:4] dma_stop)
    else $error("retry did not stop the bus");
  retry_resume_a: assert property (
    dma_stop ##0 quiet_s [*4] |=> !dma_stop)
    else $error("no resume after retry");
endmodule // ebc_top_asserts
bind ebc_top ebc_top_asserts ebc_top_asserts_i (.*);

// >>> tb/ebc_bus_model.sv
// Arbiter and memory side that grants the bus and runs transfers.
`timescale 1ns/1ps
module ebc_bus_model (
  input  wire aclk,
  input  wire aresetn,
  input  wire req,
  input  wire retry,
  input  wire dma_stop,
  output reg  bus_grant,
  output reg  dma_active,
  output reg  bus_retry_in
);
  // Retry is registered on the rising edge, so it moves half a cycle away from the falling-edge sample.
  always @(posedge aclk) begin
    if (!aresetn) begin
      bus_grant    <= 1'b0;
      dma_active   <= 1'b0;
      bus_retry_in <= 1'b0;
    end else begin
      bus_grant    <= req;
      dma_active   <= req && !dma_stop;
      bus_retry_in <= retry;
    end
  end
endmodule // ebc_bus_model

// >>> tb/extended_bus_config_tb.sv
// Self-checking bench for the bus configuration bank.
`timescale 1ns/1ps
`include "ebc_defines.vh"
module extended_bus_config_tb;
  reg         aclk = 0, aresetn = 0, mac_txd = 0, mac_loopback = 0;
  reg         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  reg         s_axi_arvalid = 0, s_axi_rready = 0, txc_pin_i = 0;
  reg         req = 0, retry = 0, rx = 0;
  reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg  [31:0] s_axi_wdata = 32'h0, rd;
  reg  [3:0]  s_axi_wstrb = 4'hF;
  reg  [1:0]  rsp;
  integer     bad_count = 0, checks_done = 0, i;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire        s_axi_rvalid, bus_grant, dma_active, dma_stop, bus_retry_in;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] bus_cycle_config;
  wire        mac_rx_clock, mac_rxd, mac_tx_clock, sync_term_valid;
  wire        sync_termination_in, reset_mode, user_pin_hi_o;
  wire        user_pin_lo_o, user_pin_hi_oe, user_pin_lo_oe, txd_pin_o;
  wire        txd_pin_oe, lbk_pin_o, lbk_pin_oe, rxc_pin_o, rxc_pin_oe;
  wire        rxd_pin_o, rxd_pin_oe;
  // Released txd and lbk pins are pulled up; rx stands in for the encoder side.
  wire        txd_pin_i = txd_pin_oe ? txd_pin_o : 1'b1;
  wire        lbk_pin_i = lbk_pin_oe ? lbk_pin_o : 1'b1;
  wire        rxc_pin_i = rxc_pin_oe ? rxc_pin_o : rx;
  wire        rxd_pin_i = rxd_pin_oe ? rxd_pin_o : rx;
  always #4 aclk = ~aclk;
  ebc_top ebc_top_i (.*);
  ebc_bus_model ebc_bus_model_i (.aclk(aclk), .aresetn(aresetn),
    .req(req), .retry(retry), .dma_stop(dma_stop), .bus_grant(bus_grant),
    .dma_active(dma_active), .bus_retry_in(bus_retry_in));
  task conclude;
    begin
      if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e, input [8*16-1:0] m);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("BAD %0t %0s", $time, m);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge aclk);
      #1;
    end
  endtask
  // One AXI4-Lite transfer; the master waits for the answer, bounded.
  task ax(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge aclk);
      if (w) begin
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
      end else begin
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      end
      for (n = 0; n < 40; n = n + 1) begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (w ? s_axi_bvalid : s_axi_rvalid) begin
          rsp = w ? s_axi_bresp : s_axi_rresp;
          rd = s_axi_rdata;
          s_axi_bready <= 1'b0; s_axi_rready <= 1'b0;
          n = 99;
        end
      end
      if (n < 99) begin
        bad_count = bad_count + 1;
        $display("BAD %0t timeout", $time);
        conclude;
      end
    end
  endtask
  task t_reset;
    begin
      ax(0, `EBC_ADDR_BCC, 32'h0);
      chk(rd & 32'hA000, 32'h0, "reset bits");
      ax(0, `EBC_ADDR_CTRL, 32'h0);
      chk(rd, `EBC_CTRL_RST, "ctrl reset");
      chk(reset_mode, 32'h1, "reset mode");
      chk({txd_pin_oe, lbk_pin_oe}, 32'h0, "pins float");
      ax(0, 8'h14, 32'h0);
      chk(rsp, `EBC_RESP_SLVERR, "unmapped rd");
    end
  endtask
  task t_regs;
    begin
      ax(1, `EBC_ADDR_CTRL, 32'h1);
      ax(1, `EBC_ADDR_BCC, 32'hFFFF3FFF);
      chk(rsp, `EBC_RESP_OKAY, "cfg wr");
      ax(0, `EBC_ADDR_BCC, 32'h0);
      chk(rd, 32'h3FFF, "cfg rd");
      ax(1, 8'h14, 32'h1);
      chk(rsp, `EBC_RESP_SLVERR, "unmapped wr");
    end
  endtask
  task t_user;
    begin
      ax(1, `EBC_ADDR_BCC, 32'h1000);
      tick(1);
      chk({user_pin_hi_oe, user_pin_lo_oe}, 32'h0, "user off");
      @(posedge aclk) req <= 1'b1;
      tick(2);
      chk({user_pin_hi_oe, user_pin_lo_oe, user_pin_hi_o, user_pin_lo_o},
        32'hE, "user on");
      @(posedge aclk) req <= 1'b0;
    end
  endtask
  task t_ext;
    begin
      ax(1, `EBC_ADDR_CFG2, 32'hA000);
      ax(1, `EBC_ADDR_CTRL, 32'h3);
      ax(1, `EBC_ADDR_BCC, 32'h8000);
      tick(1);
      chk({txd_pin_oe, lbk_pin_oe, rxc_pin_oe, rxd_pin_oe}, 32'h0, "ext");
      @(posedge aclk) {req, rx} <= 2'h3;
      tick(2);
      chk({txd_pin_oe, lbk_pin_oe, rxc_pin_oe, rxd_pin_oe}, 32'hF, "oe");
      chk({rxd_pin_o, rxc_pin_o, lbk_pin_o, txd_pin_o}, 32'hA, "exo");
      chk({sync_term_valid, sync_termination_in, mac_tx_clock, mac_rx_clock,
        mac_rxd}, 32'h18, "term on");
      ax(1, `EBC_ADDR_BCC, 32'h8400);
      tick(1);
      chk(sync_term_valid, 32'h0, "term sync");
      ax(1, `EBC_ADDR_CTRL, 32'h1);
      ax(1, `EBC_ADDR_BCC, 32'h8000);
      tick(1);
      chk(sync_term_valid, 32'h0, "term style");
      @(posedge aclk) req <= 1'b0;
    end
  endtask
  task t_norm;
    begin
      ax(1, `EBC_ADDR_BCC, 32'h0);
      @(posedge aclk) {mac_txd, mac_loopback, txc_pin_i, rx} <= 4'hF;
      tick(1);
      chk({txd_pin_oe, txd_pin_o, lbk_pin_oe, lbk_pin_o, mac_tx_clock,
        mac_rx_clock, mac_rxd, rxc_pin_oe, rxd_pin_oe},
        32'h1FC, "normal");
    end
  endtask
  task t_swrst;
    begin
      ax(1, `EBC_ADDR_BCC, 32'h1A5A);
      ax(1, `EBC_ADDR_CTRL, 32'h5);
      ax(0, `EBC_ADDR_BCC, 32'h0);
      chk(rd, 32'h1A5A, "soft reset");
    end
  endtask
  // Stops the bus on retry, in both sampling modes, then resumes.
  task t_retry(input [31:0] cfg, input [8*16-1:0] m);
    begin
      ax(1, `EBC_ADDR_BCC, cfg);
      ax(1, `EBC_ADDR_STAT, 32'h1);
      @(posedge aclk) req <= 1'b1;
      tick(3);
      @(posedge aclk) retry <= 1'b1;
      tick(5);
      chk(dma_stop, 32'h1, m);
      @(posedge aclk) retry <= 1'b0;
      tick(6);
      chk(dma_stop, {31'h0, cfg[13]}, m);
      if (cfg[13]) begin
        ax(0, `EBC_ADDR_STAT, 32'h0);
        chk(rd[3:0], 32'h7, "flag");
        ax(1, `EBC_ADDR_STAT, 32'h1);
        tick(4);
        chk(dma_stop, 32'h0, "resume");
      end
      @(posedge aclk) req <= 1'b0;
    end
  endtask
  task t_hwrst;
    begin
      ax(1, `EBC_ADDR_BCC, 32'hBFFF);
      @(posedge aclk) aresetn <= 1'b0;
      tick(2);
      @(posedge aclk) aresetn <= 1'b1;
      ax(0, `EBC_ADDR_BCC, 32'h0);
      chk(rd, 32'h1FFF, "hw reset");
      chk(txd_pin_oe, 32'h0, "float");
    end
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_regs;
    t_user;
    t_ext;
    t_norm;
    t_swrst;
    t_retry(32'h0000, "sync retry");
    t_retry(32'h8000, "async retry");
    t_retry(32'h2000, "latched");
    t_hwrst;
    conclude;
  end
endmodule // extended_bus_config_tb
